/* File: bench/scdt_far_model.sv */
`timescale 1ns/1ps
module scdt_far_model (
  input wire logic clk,
  input wire logic ls_off_req,
  output logic meas_valid,
  output logic [1:0] meas_sel,
  output logic [15:0] meas_code,
  output logic meas_open,
  output logic ls_on,
  output logic zc_detect,
  output logic phase_diode,
  output logic phase_spike
);
  int req_lat = -1;

  initial begin
    meas_valid = 1'b0;
    meas_sel = 2'h3;
    meas_code = 16'h0000;
    meas_open = 1'b0;
    ls_on = 1'b0;
    zc_detect = 1'b0;
    phase_diode = 1'b0;
    phase_spike = 1'b0;
  end

  // One strap reading for one cycle, called at a falling edge
  task automatic read_pin(input logic [1:0] sel, input logic [15:0] code,
                          input logic open);
    meas_valid = 1'b1;
    meas_sel = sel;
    meas_code = code;
    meas_open = open;
    @(negedge clk);
  endtask

  // Unqualified lines do not keep the last value
  task automatic idle_pins();
    meas_valid = 1'b0;
    meas_sel = 2'h3;
    meas_code = ~meas_code;
    meas_open = ~meas_open;
  endtask

  // Low-side on-time, then diode or spike at the phase node
  task automatic switch_cycle(input int diode_cyc, input logic spike);
    int n;
    n = 0;
    req_lat = -1;
    ls_on = 1'b1;
    repeat (2) @(negedge clk);
    zc_detect = 1'b1;
    while (ls_off_req !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    if (ls_off_req === 1'b1) begin
      req_lat = n;
    end
    ls_on = 1'b0;
    zc_detect = 1'b0;
    if (spike) begin
      phase_spike = 1'b1;
      repeat (2) @(negedge clk);
    end else begin
      phase_diode = 1'b1;
      repeat (diode_cyc) @(negedge clk);
    end
    phase_spike = 1'b0;
    phase_diode = 1'b0;
  endtask
endmodule

/* File: bench/strap_config_and_deadtime_trim_bench.sv */
`timescale 1ns/1ps
module strap_config_and_deadtime_trim_bench;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic softstart = 1'b0;
  logic dcm = 1'b0;
  logic sv, so, ls, zc, pd, ps, flt, valid, err, req;
  logic [1:0] ss;
  logic [15:0] sc;
  logic signed [15:0] core_off, aux_off;
  logic [7:0] slew;
  logic [9:0] freq;
  logic signed [5:0] trim;
  int fails = 0;
  int comparisons = 0;
  int trim_exp = 0;
  int core_mv[16] = '{-4375, -3750, -3125, -2500, -1875, -1250, -625, 625,
                      1875, 3125, 4376, 5000, 3750, 2500, 1250, 0};
  int aux_mv[8] = '{1875, 3125, 4376, 5000, 3750, 2500, 1250, 0};
  int slew_r[4] = '{200, 150, 125, 100};
  int freq_r[4] = '{450, 350, 400, 300};
  logic [15:0] codes[15] = '{16'h0232, 16'h0313, 16'h047E, 16'h069A,
    16'h07A8, 16'h09BA, 16'h0D48, 16'h1018, 16'h146E, 16'h1C98, 16'h253A,
    16'h2F44, 16'h3C28, 16'h4718, 16'h5208};

  always #5 sys_clk = ~sys_clk;

  scdt_top u_scdt_top (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .SOFTSTART_EARLY(softstart),
    .STRAP_MEAS_VALID(sv), .STRAP_MEAS_SEL(ss), .STRAP_MEAS_CODE(sc),
    .STRAP_MEAS_OPEN(so), .CORE_OFFSET(core_off), .AUX_OFFSET(aux_off),
    .SLEW_RATE(slew), .SWITCH_FREQ(freq), .FLOAT_DRV_TO_AUX(flt),
    .CONFIG_VALID(valid), .STRAP_ERR(err), .DCM_MODE(dcm), .LS_ON(ls),
    .ZC_DETECT(zc), .PHASE_DIODE(pd), .PHASE_SPIKE(ps),
    .LS_OFF_REQ(req), .ZC_TRIM(trim));

  scdt_far_model u_scdt_far_model (
    .clk(sys_clk), .ls_off_req(req), .meas_valid(sv), .meas_sel(ss),
    .meas_code(sc), .meas_open(so), .ls_on(ls), .zc_detect(zc),
    .phase_diode(pd), .phase_spike(ps));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic do_reset();
    @(negedge sys_clk);
    rst_n = 1'b0;
    softstart = 1'b0;
    repeat (5) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge sys_clk);
  endtask

  task automatic open_window();
    softstart = 1'b1;
    repeat (2) @(negedge sys_clk);
  endtask

  task automatic wait_valid();
    for (int n = 0; n < 10 && valid !== 1'b1; n++) begin
      @(negedge sys_clk);
    end
    check(32'(valid), 1);
  endtask

  task automatic read_bin(input logic [1:0] sel, input int i);
    u_scdt_far_model.read_pin(sel, i < 15 ? codes[i] : 16'h0000, i == 15);
  endtask

  task automatic test_bins();
    for (int i = 0; i < 16; i++) begin
      do_reset();
      check(32'(valid), 0);
      check(32'(slew), 100);
      check(32'(freq), 300);
      check(32'(flt), 1);
      open_window();
      read_bin(2'h0, i);
      read_bin(2'h1, i);
      read_bin(2'h2, i);
      u_scdt_far_model.idle_pins();
      wait_valid();
      check(32'(core_off), core_mv[i]);
      check(32'(aux_off), aux_mv[i % 8]);
      check(32'(slew), slew_r[i % 4]);
      check(32'(flt), i / 8);
      check(32'(freq), freq_r[i / 4]);
      read_bin(2'h2, (i + 1) % 16);
      u_scdt_far_model.idle_pins();
      repeat (3) @(negedge sys_clk);
      check(32'(slew), slew_r[i % 4]);
      check(32'(flt), i / 8);
    end
    $display("test_bins done");
  endtask

  task automatic test_err_default();
    do_reset();
    open_window();
    u_scdt_far_model.read_pin(2'h0, 16'h0258, 1'b0);
    read_bin(2'h2, 0);
    u_scdt_far_model.idle_pins();
    repeat (3) @(negedge sys_clk);
    check(32'(err), 1);
    check(32'(valid), 0);
    softstart = 1'b0;
    wait_valid();
    check(32'(core_off), 0);
    check(32'(aux_off), 0);
    check(32'(slew), 200);
    check(32'(freq), 400);
    $display("test_err_default done");
  endtask

  task automatic dcm_cycle(input int diode, input logic spike, input int step);
    u_scdt_far_model.switch_cycle(diode, spike);
    check(32'(u_scdt_far_model.req_lat), dcm ? 1 : -1);
    repeat (8) @(negedge sys_clk);
    trim_exp += step;
    check(32'(trim), trim_exp);
  endtask

  task automatic test_dcm();
    do_reset();
    trim_exp = 0;
    dcm = 1'b1;
    dcm_cycle(6, 1'b0, 1);
    dcm_cycle(6, 1'b0, 1);
    dcm_cycle(4, 1'b0, 0);
    dcm_cycle(2, 1'b0, -1);
    dcm_cycle(0, 1'b1, -1);
    dcm = 1'b0;
    dcm_cycle(4, 1'b0, 0);
    $display("test_dcm done");
  endtask

  // Whole run needs under 10 us; allow twenty times that
  initial begin
    #200000;
    fails++;
    end_of_test();
  end

  initial begin
    test_bins();
    test_err_default();
    test_dcm();
    end_of_test();
  end
endmodule

/* File: logic/scdt_bin_classify.sv */
`timescale 1ns/1ps
`include "scdt_regs.svh"
module scdt_bin_classify (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic meas_valid,
  input wire logic [1:0] meas_sel,
  input wire logic [15:0] meas_code,
  input wire logic meas_open,
  output logic bin_valid,
  output logic bin_err,
  output logic [1:0] bin_sel,
  output scdt_pkg::scdt_bin_t bin
);
  // Tolerance limits in units of 10 ohm, lowest bin first
  localparam logic [15:0] LIM_MIN [0:14] = '{
    16'h022A, 16'h0308, 16'h046D, 16'h0681, 16'h078A, 16'h0995,
    16'h0D15, 16'h0FDA, 16'h1420, 16'h1C2A, 16'h24AB, 16'h2E8F,
    16'h3B41, 16'h4607, 16'h50CD};
  localparam logic [15:0] LIM_MAX [0:14] = '{
    16'h023A, 16'h031E, 16'h048F, 16'h06B3, 16'h07C5, 16'h09DF,
    16'h0D7B, 16'h1055, 16'h14BC, 16'h1D05, 16'h25C8, 16'h2FF9,
    16'h3D0F, 16'h4829, 16'h5343};

  logic next_bin_valid;
  logic next_bin_err;
  logic [1:0] next_bin_sel;
  scdt_pkg::scdt_bin_t next_bin;

  // Sixteen bins, open circuit last
  always_comb begin
    next_bin_valid = meas_valid;
    next_bin_sel = meas_sel;
    next_bin = `SCDT_OPEN_BIN;
    next_bin_err = meas_valid && !meas_open;
    if (!meas_open) begin
      for (int i = 0; i < 15; i++) begin
        if (meas_code >= LIM_MIN[i] && meas_code <= LIM_MAX[i]) begin
          next_bin = 4'(i);
          next_bin_err = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bin_valid <= 1'b0;
      bin_err <= 1'b0;
      bin_sel <= 2'h0;
      bin <= 4'h0;
    end else begin
      bin_valid <= next_bin_valid;
      bin_err <= next_bin_err;
      bin_sel <= next_bin_sel;
      bin <= next_bin;
    end
  end
endmodule

/* File: logic/scdt_pkg.sv */
package scdt_pkg;
  typedef logic [3:0] scdt_bin_t;
  typedef enum logic [1:0] {CF_WAIT, CF_MEASURE, CF_DONE} scdt_cf_state_t;
  typedef enum logic [1:0] {DZ_IDLE, DZ_ON, DZ_WATCH} scdt_dz_state_t;
endpackage

/* File: logic/scdt_regs.svh */
`ifndef SCDT_REGS_SVH
`define SCDT_REGS_SVH

// Strap pin selectors
`define SCDT_PIN_CORE 2'h0
`define SCDT_PIN_AUX 2'h1
`define SCDT_PIN_SLEW 2'h2

// Bin codes
`define SCDT_OPEN_BIN 4'hF
`define SCDT_UPPER_BIT 3

// Reset values of the configuration outputs
`define SCDT_RST_OFFSET 16'sh0000
`define SCDT_RST_SLEW 8'h64
`define SCDT_RST_FREQ 10'h12C
`define SCDT_RST_FLOAT 1'b1

// Timing
`define SCDT_CLK_PERIOD_NS 10
`define SCDT_BODY_DIODE_NS 40
`define SCDT_BODY_DIODE_CYC (`SCDT_BODY_DIODE_NS / `SCDT_CLK_PERIOD_NS)

`endif

/* File: logic/scdt_top.sv */
`timescale 1ns/1ps
`include "scdt_regs.svh"
// Notes on behaviour
// - In DCM, end low-side on-time when the phase comparator sees zero cross.
// - After turn-off, trim comparator threshold stepwise toward 40ns diode time.
// - Measure the three strap pins only early in soft-start, then latch.
// - Classify each strap into sixteen tolerance bins, open being the last.
// - Core offset bins map -43.75 up to +6.25, then 18.75 .. 0 mV.
// - Aux offset bins map 18.75 .. 0 mV, repeated for the upper eight.
// - Slew rate cycles 20, 15, 12.5, 10 mV/us over each group of four.
// - Slew strap low half: driver to core ch3; upper half: swapped.
// - Slew rate, once latched, never changes until reset.
// - One common slew rate for both regulators.
// - Frequency from slew and aux straps: 300/350 or 400/450 kHz.
module scdt_top #(
  parameter int TRIM_W = 6,
  parameter int CNT_W = 5
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic SOFTSTART_EARLY,
  input wire logic STRAP_MEAS_VALID,
  input wire logic [1:0] STRAP_MEAS_SEL,
  input wire logic [15:0] STRAP_MEAS_CODE,
  input wire logic STRAP_MEAS_OPEN,
  output logic signed [15:0] CORE_OFFSET,
  output logic signed [15:0] AUX_OFFSET,
  output logic [7:0] SLEW_RATE,
  output logic [9:0] SWITCH_FREQ,
  output logic FLOAT_DRV_TO_AUX,
  output logic CONFIG_VALID,
  output logic STRAP_ERR,
  input wire logic DCM_MODE,
  input wire logic LS_ON,
  input wire logic ZC_DETECT,
  input wire logic PHASE_DIODE,
  input wire logic PHASE_SPIKE,
  output logic LS_OFF_REQ,
  output logic signed [TRIM_W-1:0] ZC_TRIM
);
  localparam logic [CNT_W-1:0] DIODE_TGT = CNT_W'(`SCDT_BODY_DIODE_CYC);
  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
  localparam logic signed [TRIM_W-1:0] TRIM_MAX = {1'b0, {TRIM_W-1{1'b1}}};
  localparam logic signed [TRIM_W-1:0] TRIM_MIN = {1'b1, {TRIM_W-1{1'b0}}};

  // Offsets in units of 10 uV
  function automatic logic signed [15:0] aux_map(input scdt_pkg::scdt_bin_t b);
    case (b[2:0])
      3'h0: aux_map = 16'sh0753;
      3'h1: aux_map = 16'sh0C35;
      3'h2: aux_map = 16'sh1118;
      3'h3: aux_map = 16'sh1388;
      3'h4: aux_map = 16'sh0EA6;
      3'h5: aux_map = 16'sh09C4;
      3'h6: aux_map = 16'sh04E2;
      default: aux_map = 16'sh0000;
    endcase
  endfunction

  function automatic logic signed [15:0] core_map(input scdt_pkg::scdt_bin_t b);
    if (b[`SCDT_UPPER_BIT]) begin
      core_map = aux_map(b);
    end else begin
      case (b[2:0])
        3'h0: core_map = -16'sh1117;
        3'h1: core_map = -16'sh0EA6;
        3'h2: core_map = -16'sh0C35;
        3'h3: core_map = -16'sh09C4;
        3'h4: core_map = -16'sh0753;
        3'h5: core_map = -16'sh04E2;
        3'h6: core_map = -16'sh0271;
        default: core_map = 16'sh0271;
      endcase
    end
  endfunction

  // Slew in units of 0.1 mV/us
  function automatic logic [7:0] slew_map(input scdt_pkg::scdt_bin_t b);
    case (b[1:0])
      2'h0: slew_map = 8'hC8;
      2'h1: slew_map = 8'h96;
      2'h2: slew_map = 8'h7D;
      default: slew_map = 8'h64;
    endcase
  endfunction

  function automatic logic [9:0] freq_map(input scdt_pkg::scdt_bin_t s,
                                          input scdt_pkg::scdt_bin_t a);
    logic low_pair;
    logic high_pick;
    low_pair = (s >= 4'h4 && s <= 4'h7) || (s >= 4'hC);
    high_pick = !a[`SCDT_UPPER_BIT];
    case ({low_pair, high_pick})
      2'b10: freq_map = 10'h12C;
      2'b11: freq_map = 10'h15E;
      2'b00: freq_map = 10'h190;
      default: freq_map = 10'h1C2;
    endcase
  endfunction

  // Reset release through two flops
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  scdt_pkg::scdt_cf_state_t cf_state, next_cf_state;
  scdt_pkg::scdt_bin_t bin_core, bin_aux, bin_slew;
  scdt_pkg::scdt_bin_t next_bin_core, next_bin_aux, next_bin_slew;
  logic [2:0] got, next_got;
  logic next_err;
  logic signed [15:0] next_core_off, next_aux_off;
  logic [7:0] next_slew;
  logic [9:0] next_freq;
  logic next_float;
  logic cls_in_valid;
  logic cls_valid;
  logic cls_err;
  logic [1:0] cls_sel;
  scdt_pkg::scdt_bin_t cls_bin;

  // Strap readings accepted only in the early soft-start window
  assign cls_in_valid = STRAP_MEAS_VALID && SOFTSTART_EARLY &&
                        cf_state == scdt_pkg::CF_MEASURE;

  scdt_bin_classify u_cls (
    .clk(SYS_CLK),
    .rst_n(rst_n),
    .meas_valid(cls_in_valid),
    .meas_sel(STRAP_MEAS_SEL),
    .meas_code(STRAP_MEAS_CODE),
    .meas_open(STRAP_MEAS_OPEN),
    .bin_valid(cls_valid),
    .bin_err(cls_err),
    .bin_sel(cls_sel),
    .bin(cls_bin)
  );

  always_comb begin
    next_cf_state = cf_state;
    next_bin_core = bin_core;
    next_bin_aux = bin_aux;
    next_bin_slew = bin_slew;
    next_got = got;
    next_err = STRAP_ERR || (cls_valid && cls_err);
    case (cf_state)
      scdt_pkg::CF_WAIT: begin
        if (SOFTSTART_EARLY) begin
          next_cf_state = scdt_pkg::CF_MEASURE;
        end
      end
      scdt_pkg::CF_MEASURE: begin
        if (cls_valid && !cls_err) begin
          if (cls_sel == `SCDT_PIN_CORE) begin
            next_bin_core = cls_bin;
            next_got[0] = 1'b1;
          end else if (cls_sel == `SCDT_PIN_AUX) begin
            next_bin_aux = cls_bin;
            next_got[1] = 1'b1;
          end else if (cls_sel == `SCDT_PIN_SLEW) begin
            next_bin_slew = cls_bin;
            next_got[2] = 1'b1;
          end
        end
        if (&next_got) begin
          next_cf_state = scdt_pkg::CF_DONE;
        end else if (!SOFTSTART_EARLY) begin
          // Unread pins default to open
          if (!next_got[0]) next_bin_core = `SCDT_OPEN_BIN;
          if (!next_got[1]) next_bin_aux = `SCDT_OPEN_BIN;
          if (!next_got[2]) next_bin_slew = `SCDT_OPEN_BIN;
          next_got = 3'h7;
          next_cf_state = scdt_pkg::CF_DONE;
        end
      end
      default: begin
        next_cf_state = scdt_pkg::CF_DONE;
      end
    endcase
    if (next_cf_state == scdt_pkg::CF_DONE) begin
      next_core_off = core_map(next_bin_core);
      next_aux_off = aux_map(next_bin_aux);
      next_slew = slew_map(next_bin_slew);
      next_freq = freq_map(next_bin_slew, next_bin_aux);
      next_float = next_bin_slew[`SCDT_UPPER_BIT];
    end else begin
      next_core_off = `SCDT_RST_OFFSET;
      next_aux_off = `SCDT_RST_OFFSET;
      next_slew = `SCDT_RST_SLEW;
      next_freq = `SCDT_RST_FREQ;
      next_float = `SCDT_RST_FLOAT;
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cf_state <= scdt_pkg::CF_WAIT;
      bin_core <= `SCDT_OPEN_BIN;
      bin_aux <= `SCDT_OPEN_BIN;
      bin_slew <= `SCDT_OPEN_BIN;
      got <= 3'h0;
      STRAP_ERR <= 1'b0;
      CORE_OFFSET <= `SCDT_RST_OFFSET;
      AUX_OFFSET <= `SCDT_RST_OFFSET;
      SLEW_RATE <= `SCDT_RST_SLEW;
      SWITCH_FREQ <= `SCDT_RST_FREQ;
      FLOAT_DRV_TO_AUX <= `SCDT_RST_FLOAT;
      CONFIG_VALID <= 1'b0;
    end else begin
      cf_state <= next_cf_state;
      bin_core <= next_bin_core;
      bin_aux <= next_bin_aux;
      bin_slew <= next_bin_slew;
      got <= next_got;
      STRAP_ERR <= next_err;
      CORE_OFFSET <= next_core_off;
      AUX_OFFSET <= next_aux_off;
      SLEW_RATE <= next_slew;
      SWITCH_FREQ <= next_freq;
      FLOAT_DRV_TO_AUX <= next_float;
      CONFIG_VALID <= next_cf_state == scdt_pkg::CF_DONE;
    end
  end

  // Light-load low-side turn-off and threshold trim
  scdt_pkg::scdt_dz_state_t dz_state, next_dz_state;
  logic [CNT_W-1:0] dz_cnt, next_dz_cnt;
  logic dz_rev, next_dz_rev;
  logic dz_done;
  logic next_ls_off;
  logic signed [TRIM_W-1:0] next_trim;

  always_comb begin
    next_dz_state = dz_state;
    next_dz_cnt = dz_cnt;
    next_dz_rev = dz_rev;
    next_trim = ZC_TRIM;
    dz_done = 1'b0;
    next_ls_off = 1'b0;
    case (dz_state)
      scdt_pkg::DZ_IDLE: begin
        if (DCM_MODE && LS_ON) next_dz_state = scdt_pkg::DZ_ON;
      end
      scdt_pkg::DZ_ON: begin
        next_ls_off = DCM_MODE && LS_ON && ZC_DETECT;
        if (!LS_ON) begin
          next_dz_state = scdt_pkg::DZ_WATCH;
          next_dz_cnt = CNT_W'(PHASE_DIODE);
          next_dz_rev = 1'b0;
        end
      end
      default: begin
        next_dz_rev = dz_rev || PHASE_SPIKE;
        if (PHASE_DIODE && !LS_ON && dz_cnt != CNT_MAX) begin
          next_dz_cnt = dz_cnt + 1'b1;
        end else begin
          dz_done = 1'b1;
          next_dz_state = LS_ON ? scdt_pkg::DZ_ON : scdt_pkg::DZ_IDLE;
          if (next_dz_rev || dz_cnt < DIODE_TGT) begin
            if (ZC_TRIM != TRIM_MIN) next_trim = ZC_TRIM - 2'sb01;
          end else if (dz_cnt > DIODE_TGT) begin
            if (ZC_TRIM != TRIM_MAX) next_trim = ZC_TRIM + 2'sb01;
          end
        end
      end
    endcase
    if (!DCM_MODE) begin
      next_dz_state = scdt_pkg::DZ_IDLE;
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      dz_state <= scdt_pkg::DZ_IDLE;
      dz_cnt <= '0;
      dz_rev <= 1'b0;
      LS_OFF_REQ <= 1'b0;
      ZC_TRIM <= '0;
    end else begin
      dz_state <= next_dz_state;
      dz_cnt <= next_dz_cnt;
      dz_rev <= next_dz_rev;
      LS_OFF_REQ <= next_ls_off;
      ZC_TRIM <= next_trim;
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!rst_n);

  AST_LS_OFF: assert property (
    dz_state == scdt_pkg::DZ_ON && DCM_MODE && LS_ON && ZC_DETECT
    |=> LS_OFF_REQ) else $error("Low-side turn-off not requested");
  AST_TRIM_UP: assert property (
    dz_done && !dz_rev && !PHASE_SPIKE && dz_cnt > DIODE_TGT
    && ZC_TRIM != TRIM_MAX |=> ZC_TRIM == $past(ZC_TRIM) + 2'sb01)
    else $error("Trim did not rise on long diode time");
  AST_TRIM_DN: assert property (
    dz_done && dz_cnt < DIODE_TGT && ZC_TRIM != TRIM_MIN
    |=> ZC_TRIM == $past(ZC_TRIM) - 2'sb01)
    else $error("Trim did not fall on short diode time");
  AST_NO_LATE_CAPTURE: assert property (
    !SOFTSTART_EARLY ##1 !SOFTSTART_EARLY |-> !cls_valid)
    else $error("Strap taken outside the soft-start window");
  AST_LOW_BIN: assert property (
    cls_in_valid && !STRAP_MEAS_OPEN && STRAP_MEAS_CODE == 16'h0232
    |=> cls_valid && !cls_err && cls_bin == 4'h0)
    else $error("Lowest strap bin misclassified");
  AST_CORE_MAP: assert property (
    CONFIG_VALID |-> CORE_OFFSET == core_map(bin_core))
    else $error("Core offset does not match its strap");
  AST_AUX_MAP: assert property (
    CONFIG_VALID |-> AUX_OFFSET == aux_map(bin_aux))
    else $error("Aux offset does not match its strap");
  AST_SLEW_MAP: assert property (
    CONFIG_VALID |-> SLEW_RATE == slew_map(bin_slew))
    else $error("Slew rate does not match its strap");
  AST_DRV_SWAP: assert property (
    CONFIG_VALID |-> FLOAT_DRV_TO_AUX == (bin_slew >= 4'h8))
    else $error("Driver assignment wrong");
  AST_SLEW_LOCK: assert property (
    CONFIG_VALID |=> CONFIG_VALID && $stable(SLEW_RATE) [*2])
    else $error("Slew rate changed after latch");
  AST_FREQ: assert property (
    CONFIG_VALID && bin_slew == 4'h0 && bin_aux == 4'h0
    |-> SWITCH_FREQ == 10'h1C2) else $error("Frequency selection wrong");
  AST_DEFAULTS: assert property (
    !CONFIG_VALID |-> CORE_OFFSET == `SCDT_RST_OFFSET
    && SWITCH_FREQ == `SCDT_RST_FREQ && SLEW_RATE == `SCDT_RST_SLEW)
    else $error("Defaults not held before valid");

  COV_CONFIG: cover property (!CONFIG_VALID ##1 CONFIG_VALID);
  COV_LS_OFF: cover property (LS_OFF_REQ);
  COV_TRIM_UP: cover property (dz_done && dz_cnt > DIODE_TGT);
  COV_REV: cover property (dz_done && dz_rev);
endmodule
